// ==== rtl/lcd_ctl_pkg.sv ====
package lcd_ctl_pkg;

  // register indices carried in the low seven bits of the header byte
  localparam logic [6:0] IDX_PIXDBL = 7'h09;
  localparam logic [6:0] IDX_LSHIFT = 7'h0B;
  localparam logic [6:0] IDX_CAMP = 7'h0C;
  localparam logic [6:0] IDX_CCTR = 7'h0D;
  localparam logic [6:0] IDX_CMDRST = 7'h0F;
  localparam logic [6:0] IDX_CONV = 7'h18;
  localparam logic [6:0] IDX_BOOST = 7'h19;

  // implemented bits of each register
  localparam logic [7:0] MASK_PIXDBL = 8'h01;
  localparam logic [7:0] MASK_LSHIFT = 8'h03;
  localparam logic [7:0] MASK_CAMP = 8'h0F;
  localparam logic [7:0] MASK_CCTR = 8'h7F;
  localparam logic [7:0] MASK_CONV = 8'h7D;
  localparam logic [7:0] MASK_BOOST = 8'h1F;

  // field positions
  localparam int DBL_BIT = 0;
  localparam int LS_GATE_BIT = 0;
  localparam int LS_DRV_BIT = 1;
  localparam int CMD_RST_BIT = 0;
  localparam int CONV_ON_BIT = 0;
  localparam int CONV_DRV_BIT = 2;
  localparam int CONV_DC2_BIT = 3;
  localparam int CONV_NEG1_BIT = 4;
  localparam int CONV_NEG2_BIT = 5;
  localparam int CONV_REG_BIT = 6;
  localparam int BST_STEP_BIT = 0;
  localparam int BST_MODE_BIT = 1;
  localparam int BST_VR_LSB = 2;
  localparam int BST_VR_MSB = 4;
  localparam int AMP_MSB = 3;
  localparam int CTR_MSB = 6;

  // serial frame: header byte (read flag + index), then data byte
  localparam logic [4:0] HDR_BITS = 5'h08;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam int RD_FLAG_BIT = 7;

  // pixel path
  localparam int PIX_W = 18;
  localparam logic [7:0] NUM_OUTPUTS = 8'hF4;
  localparam logic [7:0] STEP_ONE = 8'h01;
  localparam logic [7:0] STEP_TWO = 8'h02;
  localparam int LINE_W = 12;

  typedef struct packed {
    logic [7:0] pixdbl;
    logic [7:0] lshift;
    logic [7:0] camp;
    logic [7:0] cctr;
    logic [7:0] conv;
    logic [7:0] boost;
  } regs_t;

  localparam regs_t REGS_RST = '{default: 8'h00};

  typedef struct packed {
    logic converter_on;
    logic driver_booster_enable;
    logic second_output_booster_enable;
    logic first_negative_booster_enable;
    logic second_negative_booster_enable;
    logic regulator_enable;
    logic boost_step_count;
    logic boost_mode_select;
    logic [2:0] regulator_level;
  } conv_ctrl_t;

  typedef struct packed {
    logic gate_rail_first;
    logic driver_rail_first;
  } rail_sel_t;

  typedef struct packed {
    logic [3:0] amp;
    logic [6:0] center;
  } com_dac_t;

  typedef struct packed {
    logic we;
    logic pair;
    logic [7:0] pos;
    logic [PIX_W-1:0] data;
  } pix_out_t;

  typedef struct packed {
    regs_t regs;
    logic cmd_rst;
    logic scl;
    logic [4:0] cnt;
    logic [7:0] sh;
    logic [7:0] hdr;
    logic [7:0] tx;
    logic so;
    logic so_en;
    logic [7:0] pos;
    pix_out_t pix;
  } top_state_t;

  localparam top_state_t TOP_RST = '{regs: REGS_RST, default: '0};

  typedef struct packed {
    logic [LINE_W-1:0] cnt;
    logic [LINE_W-1:0] half;
    logic pend;
    logic shift;
  } gate_state_t;

  localparam gate_state_t GATE_RST = '{default: '0};

endpackage

// ==== rtl/gate_scan.sv ====
`timescale 1ns/1ns
`default_nettype none
module gate_scan (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // line timing
  input wire logic line_start,
  input wire logic dbl,
  // gate scan pulse
  output logic gate_shift
);

  lcd_ctl_pkg::gate_state_t q, d;
  localparam logic [lcd_ctl_pkg::LINE_W-1:0] CNT_MAX = '1;
  localparam logic [lcd_ctl_pkg::LINE_W-1:0] CNT_ONE = 12'h001;

  always_comb begin
    d = q;
    d.shift = 1'b0;
    if (line_start) begin
      // half of the line just ended times the second scan of the next one
      d.half = q.cnt >> 1;
      d.cnt = '0;
      d.shift = 1'b1;
      d.pend = dbl;
    end else begin
      if (q.cnt != CNT_MAX) begin
        d.cnt = q.cnt + CNT_ONE;
      end
      if (q.pend && q.cnt == q.half) begin
        d.shift = 1'b1;
        d.pend = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= lcd_ctl_pkg::GATE_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  assign gate_shift = q.shift;

endmodule
`default_nettype wire

// ==== rtl/lcd_ctl_regs.sv ====
`timescale 1ns/1ns
`default_nettype none
// Function
// - bit 0 selects normal or pixel doubling
// - doubled pixel also drives adjacent output
// - next pixel lands after the duplicate
// - doubling scans two gate lines per line
// - bit 0 picks gate group low rail
// - bit 1 picks driver group low rail
// - rail and DAC writes act at once
// - amplitude DAC code in bits 0-3
// - center DAC code in bits 0-6
// - command reset restores defaults, upper bits ignored
// - command reset bit clears itself
// - bit 0 switches whole converter
// - bits 2-5 boosters, bit 6 regulator
// - bit 0 selects double or triple step
// - bit 1 selects single or dual boost
// - bits 2-4 select regulator voltage
module lcd_ctl_regs (
  // clock, reset, enable
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic CE,
  // serial command port
  input wire logic CSB_N,
  input wire logic SCL,
  input wire logic SI,
  output logic SO,
  output logic SO_OE,
  // incoming pixel stream
  input wire logic LINE_START,
  input wire logic PIX_VALID,
  input wire logic [lcd_ctl_pkg::PIX_W-1:0] PIX_DATA,
  // driver output writes
  output lcd_ctl_pkg::pix_out_t PIX_OUT,
  // gate scan
  output logic GATE_SHIFT,
  // analog controls
  output lcd_ctl_pkg::rail_sel_t RAIL_SEL,
  output lcd_ctl_pkg::com_dac_t COM_DAC,
  output lcd_ctl_pkg::conv_ctrl_t CONV_CTRL,
  // mode status
  output logic PIXEL_DOUBLING
);

  lcd_ctl_pkg::top_state_t q, d;
  logic dbl;
  logic scl_rise;
  logic scl_fall;
  logic [7:0] rx_byte;

  function automatic logic [7:0] rd_val(
    input lcd_ctl_pkg::regs_t r,
    input logic cmd,
    input logic [6:0] idx
  );
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      lcd_ctl_pkg::IDX_PIXDBL: begin
        v = r.pixdbl;
      end
      lcd_ctl_pkg::IDX_LSHIFT: begin
        v = r.lshift;
      end
      lcd_ctl_pkg::IDX_CAMP: begin
        v = r.camp;
      end
      lcd_ctl_pkg::IDX_CCTR: begin
        v = r.cctr;
      end
      lcd_ctl_pkg::IDX_CMDRST: begin
        v[lcd_ctl_pkg::CMD_RST_BIT] = cmd;
      end
      lcd_ctl_pkg::IDX_CONV: begin
        v = r.conv;
      end
      lcd_ctl_pkg::IDX_BOOST: begin
        v = r.boost;
      end
      default: begin
        v = 8'h00;
      end
    endcase
    return v;
  endfunction

  assign dbl = q.regs.pixdbl[lcd_ctl_pkg::DBL_BIT];
  assign scl_rise = SCL && !q.scl;
  assign scl_fall = !SCL && q.scl;
  assign rx_byte = {q.sh[6:0], SI};

  always_comb begin
    d = q;
    d.scl = SCL;
    d.pix.we = 1'b0;
    d.pix.pair = 1'b0;

    // pending command reset; registers restored one cycle after the write
    if (q.cmd_rst) begin
      d.regs = lcd_ctl_pkg::REGS_RST;
      d.cmd_rst = 1'b0;
    end

    // serial frame
    if (CSB_N) begin
      d.cnt = '0;
      d.so_en = 1'b0;
      d.so = 1'b0;
    end else begin
      // bits past the data byte are ignored until deselect
      if (scl_rise && q.cnt != lcd_ctl_pkg::FRAME_BITS) begin
        d.sh = rx_byte;
        d.cnt = q.cnt + 5'h01;
        if (q.cnt == lcd_ctl_pkg::HDR_BITS - 5'h01) begin
          d.hdr = rx_byte;
          d.tx = rd_val(q.regs, q.cmd_rst, rx_byte[6:0]);
        end
        if (q.cnt == lcd_ctl_pkg::FRAME_BITS - 5'h01
            && !q.hdr[lcd_ctl_pkg::RD_FLAG_BIT]) begin
          // new values drive outputs from the next edge on
          case (q.hdr[6:0])
            lcd_ctl_pkg::IDX_PIXDBL: begin
              d.regs.pixdbl = rx_byte & lcd_ctl_pkg::MASK_PIXDBL;
            end
            lcd_ctl_pkg::IDX_LSHIFT: begin
              d.regs.lshift = rx_byte & lcd_ctl_pkg::MASK_LSHIFT;
            end
            lcd_ctl_pkg::IDX_CAMP: begin
              d.regs.camp = rx_byte & lcd_ctl_pkg::MASK_CAMP;
            end
            lcd_ctl_pkg::IDX_CCTR: begin
              d.regs.cctr = rx_byte & lcd_ctl_pkg::MASK_CCTR;
            end
            lcd_ctl_pkg::IDX_CMDRST: begin
              // only bit 0 matters
              if (rx_byte[lcd_ctl_pkg::CMD_RST_BIT]) begin
                d.cmd_rst = 1'b1;
              end
            end
            lcd_ctl_pkg::IDX_CONV: begin
              // prohibited bits are dropped rather than stored
              d.regs.conv = rx_byte & lcd_ctl_pkg::MASK_CONV;
            end
            lcd_ctl_pkg::IDX_BOOST: begin
              d.regs.boost = rx_byte & lcd_ctl_pkg::MASK_BOOST;
            end
            default: begin
              d.regs = d.regs;
            end
          endcase
        end
      end
      // read data leaves on falling edges so the host samples on rising ones
      if (scl_fall && q.hdr[lcd_ctl_pkg::RD_FLAG_BIT]
          && q.cnt >= lcd_ctl_pkg::HDR_BITS
          && q.cnt < lcd_ctl_pkg::FRAME_BITS) begin
        d.so = q.tx[7];
        d.tx = {q.tx[6:0], 1'b0};
        d.so_en = 1'b1;
      end
    end

    // pixel placement
    if (LINE_START) begin
      d.pos = '0;
    end else if (PIX_VALID && q.pos < lcd_ctl_pkg::NUM_OUTPUTS) begin
      d.pix.we = 1'b1;
      d.pix.pos = q.pos;
      d.pix.data = PIX_DATA;
      // last output has no neighbour to copy into
      d.pix.pair = dbl && (q.pos < lcd_ctl_pkg::NUM_OUTPUTS - lcd_ctl_pkg::STEP_ONE);
      if (dbl) begin
        d.pos = 8'(q.pos + lcd_ctl_pkg::STEP_TWO);
      end else begin
        d.pos = 8'(q.pos + lcd_ctl_pkg::STEP_ONE);
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      q <= lcd_ctl_pkg::TOP_RST;
    end else if (CE) begin
      q <= d;
    end
  end

  gate_scan u_gate (
    .clk(CLK),
    .arst_n(ARST_N),
    .ce(CE),
    .line_start(LINE_START),
    .dbl(dbl),
    .gate_shift(GATE_SHIFT)
  );

  assign SO = q.so;
  assign SO_OE = q.so_en;
  assign PIX_OUT = q.pix;
  assign PIXEL_DOUBLING = dbl;

  assign RAIL_SEL.gate_rail_first = q.regs.lshift[lcd_ctl_pkg::LS_GATE_BIT];
  assign RAIL_SEL.driver_rail_first = q.regs.lshift[lcd_ctl_pkg::LS_DRV_BIT];
  assign COM_DAC.amp = q.regs.camp[lcd_ctl_pkg::AMP_MSB:0];
  assign COM_DAC.center = q.regs.cctr[lcd_ctl_pkg::CTR_MSB:0];

  assign CONV_CTRL.converter_on = q.regs.conv[lcd_ctl_pkg::CONV_ON_BIT];
  assign CONV_CTRL.driver_booster_enable = q.regs.conv[lcd_ctl_pkg::CONV_DRV_BIT];
  assign CONV_CTRL.second_output_booster_enable = q.regs.conv[lcd_ctl_pkg::CONV_DC2_BIT];
  assign CONV_CTRL.first_negative_booster_enable = q.regs.conv[lcd_ctl_pkg::CONV_NEG1_BIT];
  assign CONV_CTRL.second_negative_booster_enable = q.regs.conv[lcd_ctl_pkg::CONV_NEG2_BIT];
  assign CONV_CTRL.regulator_enable = q.regs.conv[lcd_ctl_pkg::CONV_REG_BIT];
  assign CONV_CTRL.boost_step_count = q.regs.boost[lcd_ctl_pkg::BST_STEP_BIT];
  assign CONV_CTRL.boost_mode_select = q.regs.boost[lcd_ctl_pkg::BST_MODE_BIT];
  assign CONV_CTRL.regulator_level =
    q.regs.boost[lcd_ctl_pkg::BST_VR_MSB:lcd_ctl_pkg::BST_VR_LSB];

endmodule
`default_nettype wire

// ==== verif/lcd_ctl_sva.sv ====
`timescale 1ns/1ns
`default_nettype none
module lcd_ctl_sva (
  // clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic CE,
  // watched ports
  input wire logic CSB_N,
  input wire logic SO_OE,
  input wire logic LINE_START,
  input wire logic PIX_VALID,
  input wire logic [lcd_ctl_pkg::PIX_W-1:0] PIX_DATA,
  input wire lcd_ctl_pkg::pix_out_t PIX_OUT,
  input wire logic GATE_SHIFT,
  input wire lcd_ctl_pkg::rail_sel_t RAIL_SEL,
  input wire lcd_ctl_pkg::com_dac_t COM_DAC,
  input wire lcd_ctl_pkg::conv_ctrl_t CONV_CTRL,
  input wire logic PIXEL_DOUBLING
);
  default clocking @(posedge CLK); endclocking
  // frozen cycles stretch pulses, so they are not judged
  default disable iff (!ARST_N || !CE);
  sequence dbl_pair;
    PIX_OUT.we && PIXEL_DOUBLING && PIX_OUT.pos < 8'hF2 ##1 PIX_OUT.we;
  endsequence
  sequence one_pair;
    PIX_OUT.we && !PIXEL_DOUBLING ##1 PIX_OUT.we;
  endsequence
  a_pix_taken: assert property (PIX_OUT.we |-> $past(PIX_VALID) && !$past(LINE_START))
    else $error("write without pixel");
  a_pix_data: assert property (PIX_OUT.we |-> PIX_OUT.data == $past(PIX_DATA))
    else $error("pixel data wrong");
  a_pair_mode: assert property (PIX_OUT.we && PIX_OUT.pos != 8'hF3 |-> PIX_OUT.pair == PIXEL_DOUBLING)
    else $error("pair flag wrong");
  a_step_two: assert property (dbl_pair |-> PIX_OUT.pos == 8'($past(PIX_OUT.pos) + 8'h02))
    else $error("doubled step wrong");
  a_step_one: assert property (one_pair |-> PIX_OUT.pos == 8'($past(PIX_OUT.pos) + 8'h01))
    else $error("normal step wrong");
  a_gate_line: assert property (LINE_START |=> GATE_SHIFT)
    else $error("no gate pulse");
  a_gate_single: assert property (GATE_SHIFT && !PIXEL_DOUBLING |-> $past(LINE_START))
    else $error("extra gate pulse");
  a_dac_quiet: assert property ($changed(COM_DAC) |-> $past(!CSB_N))
    else $error("dac moved outside frame");
  a_rail_quiet: assert property ($changed(RAIL_SEL) |-> $past(!CSB_N))
    else $error("rail moved outside frame");
  a_conv_quiet: assert property ($changed(CONV_CTRL) |-> $past(!CSB_N))
    else $error("converter moved outside frame");
  a_so_release: assert property (CSB_N |=> !SO_OE)
    else $error("read drive left on after deselect");
endmodule
bind lcd_ctl_regs lcd_ctl_sva u_sva (.CLK(CLK), .ARST_N(ARST_N), .CE(CE), .CSB_N(CSB_N),
  .SO_OE(SO_OE),
  .LINE_START(LINE_START), .PIX_VALID(PIX_VALID), .PIX_DATA(PIX_DATA), .PIX_OUT(PIX_OUT),
  .GATE_SHIFT(GATE_SHIFT), .RAIL_SEL(RAIL_SEL), .COM_DAC(COM_DAC), .CONV_CTRL(CONV_CTRL),
  .PIXEL_DOUBLING(PIXEL_DOUBLING));
`default_nettype wire

// ==== verif/lcd_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module lcd_host_model (
  // clock
  input wire logic CLK,
  // serial lines
  output logic CSB_N,
  output logic SCL,
  output logic SI,
  input wire logic SO,
  input wire logic SO_OE
);
  initial begin
    CSB_N = 1'b1;
    SCL = 1'b0;
    SI = 1'b0;
  end
  task automatic xfer(input logic rd, input logic [6:0] idx, input logic [7:0] wd,
    output logic [7:0] rdat);
    logic [15:0] fr;
    fr = {rd, idx, wd};
    rdat = 8'h00;
    @(posedge CLK);
    CSB_N <= 1'b0;
    for (int b = 15; b >= 0; b--) begin
      @(posedge CLK);
      SCL <= 1'b0;
      // released data line toggles so a stale level is never read as valid
      SI <= (b < 8 && rd) ? ~SI : fr[b];
      repeat (2) @(posedge CLK);
      SCL <= 1'b1;
      // an undriven line reads inverted so a missing drive shows up
      if (b < 8) rdat[b] = SO_OE ? SO : ~SO;
      @(posedge CLK);
    end
    @(posedge CLK);
    CSB_N <= 1'b1;
    @(posedge CLK);
  endtask
endmodule
`default_nettype wire

// ==== verif/lcd_ctl_regs_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module lcd_ctl_regs_test;
  logic CLK = 1'b0;
  logic ARST_N = 1'b0;
  logic CE = 1'b1;
  logic CSB_N, SCL, SI, SO, SO_OE, GATE_SHIFT, PIXEL_DOUBLING;
  logic LINE_START = 1'b0;
  logic PIX_VALID = 1'b0;
  logic [lcd_ctl_pkg::PIX_W-1:0] PIX_DATA = '0;
  lcd_ctl_pkg::pix_out_t PIX_OUT;
  lcd_ctl_pkg::rail_sel_t RAIL_SEL;
  lcd_ctl_pkg::com_dac_t COM_DAC;
  lcd_ctl_pkg::conv_ctrl_t CONV_CTRL;
  int bad_count = 0;
  int n_tests = 0;
  int gates = 0;
  logic [7:0] rd;
  logic [7:0] sh [6] = '{default: 8'h00};
  logic [6:0] ix [6] = '{7'h09, 7'h0B, 7'h0C, 7'h0D, 7'h18, 7'h19};
  logic [7:0] mk [6] = '{8'h01, 8'h03, 8'h0F, 8'h7F, 8'h7D, 8'h1F};
  logic [26:0] exq [$];
  always #50 CLK = ~CLK;
  lcd_host_model host (.CLK(CLK), .CSB_N(CSB_N), .SCL(SCL), .SI(SI), .SO(SO),
    .SO_OE(SO_OE));
  lcd_ctl_regs DUT (.CLK(CLK), .ARST_N(ARST_N), .CE(CE), .CSB_N(CSB_N), .SCL(SCL),
    .SI(SI), .SO(SO), .SO_OE(SO_OE), .LINE_START(LINE_START), .PIX_VALID(PIX_VALID),
    .PIX_DATA(PIX_DATA), .PIX_OUT(PIX_OUT), .GATE_SHIFT(GATE_SHIFT), .RAIL_SEL(RAIL_SEL),
    .COM_DAC(COM_DAC), .CONV_CTRL(CONV_CTRL), .PIXEL_DOUBLING(PIXEL_DOUBLING));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check_outs;
    check("doubling", PIXEL_DOUBLING, sh[0][0]);
    check("rails", RAIL_SEL, {sh[1][0], sh[1][1]});
    check("dac", COM_DAC, {sh[2][3:0], sh[3][6:0]});
    check("conv", CONV_CTRL, {sh[4][0], sh[4][2], sh[4][3], sh[4][4], sh[4][5], sh[4][6],
      sh[5][0], sh[5][1], sh[5][4:2]});
  endtask
  task automatic line(input int n, input logic dbl, input int expg);
    int g0;
    logic [17:0] pd;
    g0 = gates;
    @(posedge CLK);
    LINE_START <= 1'b1;
    for (int i = 0; i < n; i++) begin
      pd = 18'($urandom);
      exq.push_back({dbl, 8'(dbl ? 2 * i : i), pd});
      @(posedge CLK);
      LINE_START <= 1'b0;
      PIX_VALID <= 1'b1;
      PIX_DATA <= pd;
    end
    @(posedge CLK);
    LINE_START <= 1'b0;
    PIX_VALID <= 1'b0;
    // long idle so the half-line point of the previous line falls inside
    repeat (80) @(posedge CLK);
    check("gate pulses", gates - g0, expg);
  endtask
  always @(negedge CLK) begin
    if (GATE_SHIFT === 1'b1) gates++;
    if (PIX_OUT.we === 1'b1) begin
      if (exq.size() == 0) check("extra pixel", 1, 0);
      else check("pixel", {PIX_OUT.pair, PIX_OUT.pos, PIX_OUT.data}, exq.pop_front());
    end
  end
  initial begin
    repeat (60000) @(posedge CLK);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'hB69F));
    repeat (3) @(posedge CLK);
    ARST_N <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      host.xfer(1'b1, ix[i], 8'h00, rd);
      check("reset value", rd, 8'h00);
    end
    host.xfer(1'b0, 7'h05, 8'hFF, rd);
    check_outs();
    for (int k = 0; k < 26; k++) begin
      int i;
      // last rounds walk every regulator code through the boost register
      i = (k >= 18) ? 5 : k % 6;
      if (k >= 18) sh[5] = 8'({k[2:0], k[1:0]});
      else sh[i] = 8'($urandom) & mk[i];
      host.xfer(1'b0, ix[i], sh[i], rd);
      check_outs();
      host.xfer(1'b1, ix[i], 8'h00, rd);
      check("readback", rd, sh[i]);
    end
    host.xfer(1'b0, 7'h0F, 8'hFE, rd);
    check_outs();
    host.xfer(1'b0, 7'h0F, 8'h01, rd);
    sh = '{default: 8'h00};
    check_outs();
    host.xfer(1'b1, 7'h0F, 8'h00, rd);
    check("reset bit", rd, 8'h00);
    // a frozen block must let a whole frame pass unseen
    CE <= 1'b0;
    host.xfer(1'b0, 7'h09, 8'h01, rd);
    check_outs();
    CE <= 1'b1;
    line(6, 1'b0, 1);
    line(6, 1'b0, 1);
    host.xfer(1'b0, 7'h09, 8'h01, rd);
    line(6, 1'b1, 2);
    line(6, 1'b1, 2);
    check("left over", exq.size(), 0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
